//--- sdp_dev.sv
// sdram device end: command decode, bank state, byte-masked storage
// assumes pin inputs, clock enable included, are synchronous to i_sys_clk
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_dev
   import sdp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   output sdp_pkg::sdp_pwr_t o_pwr_state,
   output logic [`SDP_NBANK-1:0] o_bank_open,
   output logic [`SDP_ROW_W-1:0] o_mode,
   output logic o_cmd_err,
   sdp_if.dev pins
);
   import sdp_pkg::*;

   // command from the sampled strobe pins
   function automatic sdp_cmd_t sdp_dec(input logic cs_n, input logic [2:0] rcw);
      if (cs_n)
         sdp_dec = SDP_CMD_DESL;
      else
      begin
         case (rcw)
            3'h7: sdp_dec = SDP_CMD_NOP;
            3'h6: sdp_dec = SDP_CMD_BST;
            3'h5: sdp_dec = SDP_CMD_RD;
            3'h4: sdp_dec = SDP_CMD_WR;
            3'h3: sdp_dec = SDP_CMD_ACT;
            3'h2: sdp_dec = SDP_CMD_PRE;
            3'h1: sdp_dec = SDP_CMD_REF;
            default: sdp_dec = SDP_CMD_MRS;
         endcase
      end
   endfunction : sdp_dec

   sdp_cmd_t cmd;
   logic edge_ok;
   logic ap;
   logic [`SDP_BA_W-1:0] ba;
   logic [`SDP_MEM_AW-1:0] widx;
   logic any_open;

   sdp_pwr_t pwr_ff;
   logic [`SDP_NBANK-1:0] open_ff;
   logic [`SDP_ROW_W-1:0] row_ff [`SDP_NBANK];
   logic [`SDP_ROW_W-1:0] mode_ff;
   logic err_ff;
   wire logic [`SDP_DQ_W-1:0] mem_rd;
   logic rd1_ff;
   logic [`SDP_MEM_AW-1:0] ridx_ff;
   logic [`SDP_LANES-1:0] dqm1_ff;
   logic [`SDP_DQ_W-1:0] rdata_ff;
   logic [`SDP_LANES-1:0] oe_n_ff;

   // ------------------------------------------------
   // decode and edge qualification
   // ------------------------------------------------
   // clock enable is used live, not through a flop
   assign edge_ok = pins.cke;
   assign cmd = sdp_dec(pins.cs_n, {pins.ras_n, pins.cas_n, pins.we_n});
   assign ap = pins.addr[`SDP_AP_BIT];
   assign ba = pins.ba;
   assign any_open = |open_ff;
   // storage word: bank, low row bits of the open row, low column bits
   assign widx = {ba, row_ff[ba][`SDP_MEM_ROW_W-1:0], pins.addr[`SDP_MEM_COL_W-1:0]};

   // ------------------------------------------------
   // low-power state
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pwr_ff <= SDP_PWR_RUN;
      else
      begin
         case (pwr_ff)
            SDP_PWR_RUN:
            begin
               if (!pins.cke)
               begin
                  if (cmd == SDP_CMD_REF && !any_open)
                     pwr_ff <= SDP_PWR_SELF;
                  else if (any_open || rd1_ff)
                     pwr_ff <= SDP_PWR_SUSP;
                  else
                     pwr_ff <= SDP_PWR_DOWN;
               end
            end
            default:
            begin
               if (pins.cke)
                  pwr_ff <= SDP_PWR_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------
   // bank rows, one flop set per bank
   // ------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < `SDP_NBANK; b++)
      begin : g_bank
         always_ff @(posedge i_sys_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               open_ff[b] <= 1'b0;
               row_ff[b] <= `SDP_ROW_RST;
            end
            else if (edge_ok && pwr_ff == SDP_PWR_RUN)
            begin
               if (cmd == SDP_CMD_ACT && ba == b)
               begin
                  open_ff[b] <= 1'b1;
                  row_ff[b] <= pins.addr;
               end
               else if (cmd == SDP_CMD_PRE && (ap || ba == b))
                  open_ff[b] <= 1'b0;
               else if ((cmd == SDP_CMD_RD || cmd == SDP_CMD_WR) && ap && ba == b)
                  open_ff[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------
   // mode register and illegal-command flag
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         mode_ff <= `SDP_MODE_RST;
      else if (edge_ok && cmd == SDP_CMD_MRS && !any_open)
         mode_ff <= pins.addr;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         err_ff <= 1'b0;
      else if (edge_ok)
         err_ff <= ((cmd == SDP_CMD_RD || cmd == SDP_CMD_WR) && !open_ff[ba])
                   || (cmd == SDP_CMD_ACT && open_ff[ba])
                   || ((cmd == SDP_CMD_MRS || cmd == SDP_CMD_REF) && any_open);
      else
         err_ff <= 1'b0;
   end

   // ------------------------------------------------
   // byte-masked writes
   // ------------------------------------------------
   genvar l;
   generate
      for (l = 0; l < `SDP_LANES; l++)
      begin : g_lane
         // one byte array per lane, so each array has a single writer
         logic [`SDP_LANE_W-1:0] mem_lane [2**`SDP_MEM_AW];
         always_ff @(posedge i_sys_clk)
         begin
            if (edge_ok && cmd == SDP_CMD_WR && open_ff[ba] && !pins.dqm[l])
               mem_lane[widx] <= pins.dq[l*`SDP_LANE_W +: `SDP_LANE_W];
         end
         assign mem_rd[l*`SDP_LANE_W +: `SDP_LANE_W] = mem_lane[ridx_ff];
      end
   endgenerate

   // ------------------------------------------------
   // read pipeline: mask taken with command, applied two edges on
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd1_ff <= 1'b0;
         ridx_ff <= '0;
         dqm1_ff <= '1;
      end
      else if (edge_ok)
      begin
         rd1_ff <= cmd == SDP_CMD_RD && open_ff[ba];
         ridx_ff <= widx;
         dqm1_ff <= pins.dqm;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_ff <= '0;
         oe_n_ff <= '1;
      end
      else if (edge_ok)
      begin
         rdata_ff <= mem_rd;
         oe_n_ff <= {`SDP_LANES{!rd1_ff}} | dqm1_ff;
      end
   end

   assign pins.dq_dev = rdata_ff;
   assign pins.dq_dev_oe_n = oe_n_ff;
   assign o_pwr_state = pwr_ff;
   assign o_bank_open = open_ff;
   assign o_mode = mode_ff;
   assign o_cmd_err = err_ff;
endmodule : sdp_dev

//--- sdp_host.sv
// sdram controller end: turns one user request per cycle into pin levels
// assumes the device answers reads two edges after it takes the command
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_host
   import sdp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_req_valid,
   input wire sdp_pkg::sdp_cmd_t i_req_cmd,
   input wire logic [`SDP_BA_W-1:0] i_req_ba,
   input wire logic [`SDP_ROW_W-1:0] i_req_addr,
   input wire logic [`SDP_LANES-1:0] i_req_mask,
   input wire logic [`SDP_DQ_W-1:0] i_req_wdata,
   input wire logic i_cke,
   output logic o_rd_valid,
   output logic [`SDP_DQ_W-1:0] o_rd_data,
   sdp_if.host pins
);
   import sdp_pkg::*;

   logic cke_ff;
   logic cs_n_ff;
   logic [2:0] rcw_ff;
   logic [`SDP_BA_W-1:0] ba_ff;
   logic [`SDP_ROW_W-1:0] addr_ff;
   logic [`SDP_LANES-1:0] dqm_ff;
   logic [`SDP_DQ_W-1:0] wdata_ff;
   logic dq_oe_n_ff;
   logic [`SDP_HOST_RD_LAT-1:0] rd_pend_ff;
   logic rd_valid_ff;
   logic [`SDP_DQ_W-1:0] rd_data_ff;
   logic take;

   assign take = i_req_valid && (i_req_cmd != SDP_CMD_DESL);

   // ------------------------------------------------
   // command pins, launched from flops
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cke_ff <= `SDP_CKE_RST;
         cs_n_ff <= 1'b1;
         rcw_ff <= 3'h7;
         ba_ff <= '0;
         addr_ff <= `SDP_ROW_RST;
         dqm_ff <= '1;
      end
      else
      begin
         cke_ff <= i_cke;
         cs_n_ff <= !take;
         rcw_ff <= sdp_enc(take ? i_req_cmd : SDP_CMD_NOP);
         ba_ff <= i_req_ba;
         addr_ff <= i_req_addr;
         dqm_ff <= take ? i_req_mask : '1;
      end
   end

   // ------------------------------------------------
   // write data beside the write command, bus freed otherwise
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wdata_ff <= '0;
         dq_oe_n_ff <= 1'b1;
      end
      else
      begin
         wdata_ff <= i_req_wdata;
         dq_oe_n_ff <= !(take && i_req_cmd == SDP_CMD_WR);
      end
   end

   // ------------------------------------------------
   // read return: sample bus three edges after launch
   // ------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd_pend_ff <= '0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
      end
      else
      begin
         rd_pend_ff <= {rd_pend_ff[`SDP_HOST_RD_LAT-2:0], take && i_req_cmd == SDP_CMD_RD};
         rd_valid_ff <= rd_pend_ff[`SDP_HOST_RD_LAT-1];
         rd_data_ff <= pins.dq;
      end
   end

   assign pins.cke = cke_ff;
   assign pins.cs_n = cs_n_ff;
   assign pins.ras_n = rcw_ff[2];
   assign pins.cas_n = rcw_ff[1];
   assign pins.we_n = rcw_ff[0];
   assign pins.ba = ba_ff;
   assign pins.addr = addr_ff;
   assign pins.dqm = dqm_ff;
   assign pins.dq_host = wdata_ff;
   assign pins.dq_host_oe_n = dq_oe_n_ff;
   assign o_rd_valid = rd_valid_ff;
   assign o_rd_data = rd_data_ff;
endmodule : sdp_host

//--- sdp_if.sv
// pin bundle between sdram controller and device
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`include "sdp_params.svh"
interface sdp_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [`SDP_BA_W-1:0] ba;
   logic [`SDP_ROW_W-1:0] addr;
   logic [`SDP_LANES-1:0] dqm;
   logic [`SDP_DQ_W-1:0] dq_host;
   logic dq_host_oe_n;
   logic [`SDP_DQ_W-1:0] dq_dev;
   logic [`SDP_LANES-1:0] dq_dev_oe_n;
   logic [`SDP_DQ_W-1:0] dq;

   // ------------------------------------------------
   // wire level of the shared data pins
   // ------------------------------------------------
   always_comb
   begin
      for (int l = 0; l < `SDP_LANES; l++)
      begin
         if (!dq_host_oe_n)
            dq[l*`SDP_LANE_W +: `SDP_LANE_W] = dq_host[l*`SDP_LANE_W +: `SDP_LANE_W];
         else if (!dq_dev_oe_n[l])
            dq[l*`SDP_LANE_W +: `SDP_LANE_W] = dq_dev[l*`SDP_LANE_W +: `SDP_LANE_W];
         else
            dq[l*`SDP_LANE_W +: `SDP_LANE_W] = 8'h00;
      end
   end

   modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
                output dq_dev, dq_dev_oe_n);
   modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_host, dq_host_oe_n,
                 input dq);
endinterface : sdp_if

//--- sdp_link_assertions.sv
// pin-level checks of the link between controller end and device end
// assumes tb places it beside the sdp_if instance, one clock domain
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_link_assertions (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [`SDP_LANES-1:0] dqm,
   input wire logic dq_host_oe_n,
   input wire logic [`SDP_LANES-1:0] dq_dev_oe_n
);
   wire logic rd_cmd = !cs_n && ras_n && !cas_n && we_n;
   wire logic wr_cmd = !cs_n && ras_n && !cas_n && !we_n;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   // ------------------------------------------------
   // data pin ownership and read lane timing
   // ------------------------------------------------
   rd_lane_mask_a: assert property (rd_cmd && cke ##1 cke |=> dq_dev_oe_n == $past(dqm, 2))
      else $error("read lane enables do not follow mask two edges later");
   oe_needs_read_a: assert property (dq_dev_oe_n != 4'hF |-> $past(rd_cmd && cke, 2))
      else $error("device drives data without a read two edges before");
   oe_one_beat_a: assert property ((dq_dev_oe_n != 4'hF) && cke && !$past(rd_cmd) |=> dq_dev_oe_n == 4'hF)
      else $error("device keeps driving after a single read beat");
   wr_host_drive_a: assert property (wr_cmd |-> !dq_host_oe_n)
      else $error("controller not driving data with a write");
   host_release_a: assert property (!dq_host_oe_n |-> wr_cmd)
      else $error("controller drives data outside a write");
   rd_host_release_a: assert property (rd_cmd |-> dq_host_oe_n)
      else $error("controller holds data bus during a read");
   single_driver_a: assert property (!dq_host_oe_n |-> dq_dev_oe_n == 4'hF)
      else $error("both ends drive the data pins");
   masked_edge_a: assert property (rd_cmd && !cke |-> ##2 dq_dev_oe_n == 4'hF)
      else $error("read taken on an edge with clock enable low");

   cover property (rd_cmd ##2 dq_dev_oe_n != 4'hF);
   cover property (wr_cmd);
   cover property (rd_cmd && !cke);
endmodule : sdp_link_assertions

//--- sdp_params.svh
// constants for the sdram pin command link, shared by both ends
// assumes one 100 MHz system clock feeding controller and device
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH
`define SDP_ROW_W 12
`define SDP_COL_W 9
`define SDP_BA_W 2
`define SDP_NBANK 4
`define SDP_DQ_W 32
`define SDP_LANES 4
`define SDP_LANE_W 8
`define SDP_AP_BIT 10
`define SDP_MODE_RST 12'h000
`define SDP_ROW_RST 12'h000
`define SDP_MEM_AW 8
`define SDP_MEM_ROW_W 2
`define SDP_MEM_COL_W 4
`define SDP_HOST_RD_LAT 3
`define SDP_CKE_RST 1'b1
`endif

//--- sdp_pkg.sv
// types for the sdram pin command link
// assumes sdp_params.svh is on the include path
`include "sdp_params.svh"
package sdp_pkg;
   typedef enum logic [3:0]
   {
      SDP_CMD_DESL = 4'h0,
      SDP_CMD_NOP = 4'h1,
      SDP_CMD_BST = 4'h2,
      SDP_CMD_RD = 4'h3,
      SDP_CMD_WR = 4'h4,
      SDP_CMD_ACT = 4'h5,
      SDP_CMD_PRE = 4'h6,
      SDP_CMD_REF = 4'h7,
      SDP_CMD_MRS = 4'h8
   } sdp_cmd_t;

   typedef enum logic [1:0]
   {
      SDP_PWR_RUN = 2'h0,
      SDP_PWR_DOWN = 2'h1,
      SDP_PWR_SUSP = 2'h2,
      SDP_PWR_SELF = 2'h3
   } sdp_pwr_t;

   // pin levels {ras_n, cas_n, we_n} for each command
   function automatic logic [2:0] sdp_enc(input sdp_cmd_t c);
      case (c)
         SDP_CMD_BST: sdp_enc = 3'h6;
         SDP_CMD_RD: sdp_enc = 3'h5;
         SDP_CMD_WR: sdp_enc = 3'h4;
         SDP_CMD_ACT: sdp_enc = 3'h3;
         SDP_CMD_PRE: sdp_enc = 3'h2;
         SDP_CMD_REF: sdp_enc = 3'h1;
         SDP_CMD_MRS: sdp_enc = 3'h0;
         default: sdp_enc = 3'h7;
      endcase
   endfunction : sdp_enc
endpackage : sdp_pkg

//--- tb.sv
// self-checking bench: controller end and device end joined by sdp_if
// assumes sdp_params.svh on the include path, 100 MHz clock
`timescale 1ns/1ps
`include "sdp_params.svh"
module tb;
   import sdp_pkg::*;
   typedef struct packed {logic [1:0] ba; logic [11:0] addr; logic [3:0] wm; logic [3:0] rm;
      logic [31:0] d1; logic [31:0] d2; logic [31:0] q;} sdp_case_t;
   logic i_sys_clk, i_rst_n, i_req_valid, i_cke, o_rd_valid, o_cmd_err;
   sdp_cmd_t i_req_cmd;
   logic [1:0] i_req_ba;
   logic [11:0] i_req_addr, o_mode;
   logic [3:0] i_req_mask, o_bank_open;
   logic [31:0] i_req_wdata, o_rd_data;
   sdp_pwr_t o_pwr_state;
   int num_errors = 0, checked = 0, err_pulses = 0;
   sdp_case_t cases [8] = '{
      '{2'h0, 12'h003, 4'h1, 4'h0, 32'h11223344, 32'hA5A5A5A5, 32'hA5A5A544},
      '{2'h1, 12'h005, 4'h2, 4'h0, 32'h55667788, 32'h5A5A5A5A, 32'h5A5A775A},
      '{2'h2, 12'h00A, 4'h4, 4'h1, 32'h99AABBCC, 32'h0F0F0F0F, 32'h0FAA0F00},
      '{2'h3, 12'h00F, 4'h8, 4'h2, 32'hDDEEFF00, 32'hF0F0F0F0, 32'hDDF000F0},
      '{2'h0, 12'h1F0, 4'h0, 4'h4, 32'h01020304, 32'hC3C3C3C3, 32'hC300C3C3},
      '{2'h1, 12'h006, 4'hF, 4'h8, 32'h10203040, 32'h3C3C3C3C, 32'h00203040},
      '{2'h2, 12'h00C, 4'hA, 4'h5, 32'h13579BDF, 32'h2468ACE0, 32'h13009B00},
      '{2'h3, 12'h001, 4'h5, 4'hF, 32'hFEDCBA98, 32'h76543210, 32'h00000000}};
   sdp_cmd_t pc [3] = '{SDP_CMD_RD, SDP_CMD_REF, SDP_CMD_NOP};
   sdp_pwr_t pe [3] = '{SDP_PWR_DOWN, SDP_PWR_SELF, SDP_PWR_SUSP};

   sdp_if link ();
   sdp_host sdp_host_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
      .i_req_cmd(i_req_cmd), .i_req_ba(i_req_ba), .i_req_addr(i_req_addr),
      .i_req_mask(i_req_mask), .i_req_wdata(i_req_wdata), .i_cke(i_cke),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .pins(link.host));
   sdp_dev sdp_dev_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_pwr_state(o_pwr_state),
      .o_bank_open(o_bank_open), .o_mode(o_mode), .o_cmd_err(o_cmd_err), .pins(link.dev));
   sdp_link_assertions sdp_link_assertions_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
      .we_n(link.we_n), .dqm(link.dqm), .dq_host_oe_n(link.dq_host_oe_n),
      .dq_dev_oe_n(link.dq_dev_oe_n));

   always #5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk)
      if (o_cmd_err === 1'b1)
         err_pulses++;

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic op(input sdp_cmd_t c, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input logic [31:0] wd, input logic ck = 1'b1);
      @(negedge i_sys_clk);
      i_req_valid = 1'b1;
      i_req_cmd = c;
      {i_req_ba, i_req_addr} = {b, a};
      {i_req_mask, i_req_wdata, i_cke} = {m, wd, ck};
      @(negedge i_sys_clk);
      i_req_valid = 1'b0;
      i_req_cmd = SDP_CMD_NOP;
      // device registers the pins one edge later
      @(negedge i_sys_clk);
   endtask : op

   task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [3:0] m,
      output logic [31:0] d);
      d = 'x;
      op(SDP_CMD_RD, b, a, m, 32'h0);
      for (int k = 0; k < 8 && o_rd_valid !== 1'b1; k++)
      begin
         @(posedge i_sys_clk);
         #1;
      end
      if (o_rd_valid === 1'b1)
         d = o_rd_data;
   endtask : rd

   task automatic report_and_stop();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #20000;
      num_errors++;
      report_and_stop();
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      int n;
      logic [31:0] d;
      {i_sys_clk, i_rst_n, i_req_valid, i_cke} = 4'h1;
      i_req_cmd = SDP_CMD_NOP;
      {i_req_ba, i_req_addr, i_req_mask, i_req_wdata} = '0;
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      for (int b = 0; b < 4; b++)
         op(SDP_CMD_ACT, 2'(b), 12'h000, 4'h0, 32'h0);
      check("bank_open", 32'(o_bank_open), 32'hF);
      foreach (cases[i])
      begin
         op(SDP_CMD_WR, cases[i].ba, cases[i].addr, 4'h0, cases[i].d1);
         op(SDP_CMD_WR, cases[i].ba, cases[i].addr, cases[i].wm, cases[i].d2);
         rd(cases[i].ba, cases[i].addr, cases[i].rm, d);
         check("masked_rw", d, cases[i].q);
      end
      op(SDP_CMD_PRE, 2'h0, 12'h000, 4'h0, 32'h0);
      check("pre_one", 32'(o_bank_open), 32'hE);
      op(SDP_CMD_ACT, 2'h0, 12'h002, 4'h0, 32'h0);
      op(SDP_CMD_WR, 2'h0, 12'h003, 4'h0, 32'hCAFE0001);
      rd(2'h0, 12'h003, 4'h0, d);
      check("row_b", d, 32'hCAFE0001);
      op(SDP_CMD_PRE, 2'h0, 12'h000, 4'h0, 32'h0);
      op(SDP_CMD_ACT, 2'h0, 12'h000, 4'h0, 32'h0);
      rd(2'h0, 12'h003, 4'h0, d);
      check("row_a", d, cases[0].q);
      rd(2'h1, 12'h405, 4'h0, d);
      check("ap_read", d, cases[1].q);
      check("ap_close", 32'(o_bank_open), 32'hD);
      n = err_pulses;
      op(SDP_CMD_RD, 2'h1, 12'h005, 4'hF, 32'h0);
      op(SDP_CMD_MRS, 2'h0, 12'h0AA, 4'h0, 32'h0);
      // error pulse is counted one edge after it is raised
      @(negedge i_sys_clk);
      check("err_cnt", 32'(err_pulses - n), 32'h2);
      check("mode_kept", 32'(o_mode), 32'h0);
      op(SDP_CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
      check("pre_all", 32'(o_bank_open), 32'h0);
      op(SDP_CMD_MRS, 2'h0, 12'h123, 4'h0, 32'h0);
      check("mode_load", 32'(o_mode), 32'h123);
      op(SDP_CMD_DESL, 2'h0, 12'h000, 4'h0, 32'h0);
      op(SDP_CMD_BST, 2'h0, 12'h000, 4'h0, 32'h0);
      check("desl_bst", 32'({o_bank_open, o_mode}), 32'h0123);
      n = err_pulses;
      for (int i = 0; i < 3; i++)
      begin
         if (i == 2)
            op(SDP_CMD_ACT, 2'h0, 12'h000, 4'h0, 32'h0);
         op(pc[i], 2'h3, 12'h001, 4'hF, 32'h0, 1'b0);
         repeat (2) @(negedge i_sys_clk);
         check("pwr_low", 32'(o_pwr_state), 32'(pe[i]));
         i_cke = 1'b1;
         repeat (3) @(negedge i_sys_clk);
         check("pwr_run", 32'(o_pwr_state), 32'(SDP_PWR_RUN));
      end
      check("masked_edge", 32'(err_pulses - n), 32'h0);
      i_rst_n = 1'b0;
      #1;
      check("rst_banks", 32'(o_bank_open), 32'h0);
      check("rst_mode", 32'(o_mode), 32'h0);
      @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      op(SDP_CMD_ACT, 2'h2, 12'h000, 4'h0, 32'h0);
      check("rst_reuse", 32'(o_bank_open), 32'h4);
      report_and_stop();
   end
endmodule : tb
